// ==== logic/baro_pkg.sv ====
/*
 Constants for the barometer status and result register group.
 Assumes byte-wide register addressing on the serial port's register side.
*/
// Functional notes
// - Low-current bit: 0 (default) normal low-noise, 1 low-current conversion.
// - Low-current setting applies to one-shot and continuous conversions alike.
// - Cause bit 7 reads 1 while trimming reload runs, else 0.
// - Cause bit 2 reads 1 when any delta event has been generated.
// - Cause bit 1 flags low delta event, bit 0 high delta event.
// - Queue bit 7 reads 1 when stored count is at or above watermark.
// - Queue bit 6 reads 1 when full and a sample was overwritten.
// - Six-bit level field reports unread samples, 0 empty to 32 full.
// - Status bit 5 temperature overrun, bit 4 pressure overrun.
// - Status bit 1 new temperature, bit 0 new pressure.
// - Status register refreshed once per output-rate cycle.
// - Pressure result 24-bit two's complement, low byte 28h, high 2Ah.
// - Pressure result equals measured pressure minus stored offset.
// - Temperature result 16-bit two's complement, low 2Bh, high 2Ch.
// - Reading filter reset register resets the pressure low-pass filter.
// - Pressure offset is 16-bit two's complement in two byte registers.
package baro_pkg;
  localparam logic [7:0] OFFS_LOW_ADDR   = 8'h18;
  localparam logic [7:0] OFFS_HIGH_ADDR  = 8'h19;
  localparam logic [7:0] LOW_PWR_ADDR    = 8'h1a;
  localparam logic [7:0] CAUSE_ADDR      = 8'h25;
  localparam logic [7:0] QUEUE_ADDR      = 8'h26;
  localparam logic [7:0] STATUS_ADDR     = 8'h27;
  localparam logic [7:0] PRESS_LOW_ADDR  = 8'h28;
  localparam logic [7:0] PRESS_MID_ADDR  = 8'h29;
  localparam logic [7:0] PRESS_HIGH_ADDR = 8'h2a;
  localparam logic [7:0] TEMP_LOW_ADDR   = 8'h2b;
  localparam logic [7:0] TEMP_HIGH_ADDR  = 8'h2c;
  localparam logic [7:0] FILT_RST_ADDR   = 8'h33;
  localparam int LC_BIT      = 0;
  localparam int RSVD_BIT    = 1;
  localparam int BOOT_BIT    = 7;
  localparam int ANY_BIT     = 2;
  localparam int LOW_BIT     = 1;
  localparam int HIGH_BIT    = 0;
  localparam int WTM_BIT     = 7;
  localparam int OVW_BIT     = 6;
  localparam int T_OR_BIT    = 5;
  localparam int P_OR_BIT    = 4;
  localparam int T_DA_BIT    = 1;
  localparam int P_DA_BIT    = 0;
  localparam logic [5:0]  QUEUE_FULL    = 6'h20;
  localparam logic [7:0]  LOW_PWR_RESET = 8'h00;
  localparam logic [15:0] OFFS_RESET    = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
endpackage

// ==== logic/baro_status_regs.sv ====
/*
 Status and result register group of the barometer: event cause flags,
 queue level status, sample status, pressure and temperature results,
 pressure offset, low-power configuration and the filter-reset-on-read.
 Assumes a byte register port driven by the serial protocol engine and
 measurement, queue and trimming logic that deliver one-cycle strobes.
*/
`timescale 1ns/10ps
module baro_status_regs
  import baro_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        output_rate_tick,
  input  wire logic        press_sample_valid,
  input  wire logic [23:0] press_measured,
  input  wire logic        temp_sample_valid,
  input  wire logic [15:0] temp_measured,
  input  wire logic        trim_reload_busy,
  input  wire logic        low_delta_event,
  input  wire logic        high_delta_event,
  input  wire logic [5:0]  stored_sample_count,
  input  wire logic [4:0]  watermark_level,
  input  wire logic        queue_overwritten,
  output logic             low_current_select,
  output logic             pressure_lowpass_reset
);

  logic [7:0]  low_pwr_q, low_pwr_d;
  logic [15:0] offs_q, offs_d;
  logic [7:0]  cause_q, cause_d;
  logic [7:0]  queue_q, queue_d;
  logic [7:0]  status_q, status_d;
  logic [3:0]  pend_q, pend_d;
  logic [23:0] press_q, press_d;
  logic [15:0] temp_q, temp_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        lpf_rst_q, lpf_rst_d;
  logic        rd_cause, rd_press, rd_temp;
  logic [23:0] offs_ext;

  assign rd_cause = reg_rd && (reg_addr == CAUSE_ADDR);
  assign rd_press = reg_rd && (reg_addr == PRESS_HIGH_ADDR);
  assign rd_temp  = reg_rd && (reg_addr == TEMP_HIGH_ADDR);
  assign offs_ext = {{8{offs_q[15]}}, offs_q};

  // Configuration: host keeps the reserved bit intact and only touches
  // the low-current bit in power down, so writes are stored as given.
  always_comb begin
    low_pwr_d = low_pwr_q;
    offs_d    = offs_q;
    if (reg_wr) begin
      unique case (reg_addr)
        LOW_PWR_ADDR:   low_pwr_d = reg_wdata;
        OFFS_LOW_ADDR:  offs_d[7:0] = reg_wdata;
        OFFS_HIGH_ADDR: offs_d[15:8] = reg_wdata;
        default:        low_pwr_d = low_pwr_q;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      low_pwr_q <= LOW_PWR_RESET;
      offs_q    <= OFFS_RESET;
    end else begin
      low_pwr_q <= low_pwr_d;
      offs_q    <= offs_d;
    end
  end

  // Delta event flags are sticky until read, boot bit follows reload; an event in the read cycle wins.
  always_comb begin
    cause_d = BYTE_ZERO;
    cause_d[BOOT_BIT] = trim_reload_busy;
    cause_d[LOW_BIT]  = (cause_q[LOW_BIT] && !rd_cause) || low_delta_event;
    cause_d[HIGH_BIT] = (cause_q[HIGH_BIT] && !rd_cause) || high_delta_event;
    cause_d[ANY_BIT]  = cause_d[LOW_BIT] || cause_d[HIGH_BIT];
  end

  // Queue status mirrors the queue logic; count is capped at full.
  always_comb begin
    queue_d = BYTE_ZERO;
    queue_d[5:0] = (stored_sample_count > QUEUE_FULL) ? QUEUE_FULL
                                                      : stored_sample_count;
    queue_d[WTM_BIT] = (stored_sample_count >= {1'b0, watermark_level});
    queue_d[OVW_BIT] = queue_overwritten &&
                       (stored_sample_count >= QUEUE_FULL);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cause_q <= BYTE_ZERO;
      queue_q <= BYTE_ZERO;
    end else begin
      cause_q <= cause_d;
      queue_q <= queue_d;
    end
  end

  // New samples are gathered in pending bits during an output-rate cycle
  // and committed to the status register only on the cycle tick, so the
  // host never sees a half-updated status. Reading a result's high byte
  // clears its available and overrun bits; a commit in the same cycle wins.
  always_comb begin
    pend_d   = pend_q;
    status_d = status_q;
    press_d  = press_q;
    temp_d   = temp_q;
    if (press_sample_valid) begin
      press_d = press_measured - offs_ext;
      pend_d[P_DA_BIT] = 1'b1;
      pend_d[2] = pend_q[P_DA_BIT] || status_q[P_DA_BIT];
    end
    if (temp_sample_valid) begin
      temp_d = temp_measured;
      pend_d[T_DA_BIT] = 1'b1;
      pend_d[3] = pend_q[T_DA_BIT] || status_q[T_DA_BIT];
    end
    if (rd_press) begin
      status_d[P_DA_BIT] = 1'b0;
      status_d[P_OR_BIT] = 1'b0;
    end
    if (rd_temp) begin
      status_d[T_DA_BIT] = 1'b0;
      status_d[T_OR_BIT] = 1'b0;
    end
    if (output_rate_tick) begin
      status_d[P_DA_BIT] = status_d[P_DA_BIT] || pend_d[P_DA_BIT];
      status_d[T_DA_BIT] = status_d[T_DA_BIT] || pend_d[T_DA_BIT];
      status_d[P_OR_BIT] = status_d[P_OR_BIT] || pend_d[2];
      status_d[T_OR_BIT] = status_d[T_OR_BIT] || pend_d[3];
      pend_d = 4'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pend_q   <= 4'h0;
      status_q <= BYTE_ZERO;
      press_q  <= 24'h000000;
      temp_q   <= 16'h0000;
    end else begin
      pend_q   <= pend_d;
      status_q <= status_d;
      press_q  <= press_d;
      temp_q   <= temp_d;
    end
  end

  // Read data is registered; unmapped addresses return zero.
  always_comb begin
    rdata_d   = rdata_q;
    lpf_rst_d = 1'b0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFFS_LOW_ADDR:   rdata_d = offs_q[7:0];
        OFFS_HIGH_ADDR:  rdata_d = offs_q[15:8];
        LOW_PWR_ADDR:    rdata_d = low_pwr_q;
        CAUSE_ADDR:      rdata_d = cause_q;
        QUEUE_ADDR:      rdata_d = queue_q;
        STATUS_ADDR:     rdata_d = status_q;
        PRESS_LOW_ADDR:  rdata_d = press_q[7:0];
        PRESS_MID_ADDR:  rdata_d = press_q[15:8];
        PRESS_HIGH_ADDR: rdata_d = press_q[23:16];
        TEMP_LOW_ADDR:   rdata_d = temp_q[7:0];
        TEMP_HIGH_ADDR:  rdata_d = temp_q[15:8];
        FILT_RST_ADDR: begin
          rdata_d   = BYTE_ZERO;
          lpf_rst_d = 1'b1;
        end
        default:         rdata_d = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q   <= BYTE_ZERO;
      lpf_rst_q <= 1'b0;
    end else begin
      rdata_q   <= rdata_d;
      lpf_rst_q <= lpf_rst_d;
    end
  end

  // One select serves both conversion kinds; the engine has no other copy.
  assign low_current_select     = low_pwr_q[LC_BIT];
  assign pressure_lowpass_reset = lpf_rst_q;
  assign reg_rdata              = rdata_q;

  // Free-running checks start from a cycle already out of reset: the flops
  // still hold reset values one edge after reset falls.
  sequence s_filt_read;
    reg_rd && reg_addr == FILT_RST_ADDR;
  endsequence

  sequence s_low_event;
    low_delta_event;
  endsequence

  sequence s_press_sample;
    press_sample_valid;
  endsequence

  sequence s_rate_wait;
    !rd_press && !output_rate_tick;
  endsequence

  sequence s_rate_commit;
    output_rate_tick && !rd_press;
  endsequence

  sequence s_temp_sample;
    temp_sample_valid;
  endsequence

  sequence s_temp_wait;
    !rd_temp && !output_rate_tick;
  endsequence

  sequence s_temp_commit;
    output_rate_tick && !rd_temp;
  endsequence

  a_filter_reset_pulse: assert property (@(posedge mclk) disable iff (reset)
    s_filt_read |=> pressure_lowpass_reset)
    else $error("filter reset pulse missing after read");

  a_filter_reset_cause: assert property (@(posedge mclk) disable iff (reset)
    pressure_lowpass_reset |-> $past(reg_rd) && $past(reg_addr) == FILT_RST_ADDR)
    else $error("filter reset without read");

  a_boot_bit_track: assert property (@(posedge mclk) disable iff (reset)
    !reset |=> cause_q[BOOT_BIT] == $past(trim_reload_busy))
    else $error("boot bit does not track reload");

  a_cause_zero_bits: assert property (@(posedge mclk) disable iff (reset)
    cause_q[6:3] == 4'h0 && cause_q[ANY_BIT] == (cause_q[LOW_BIT] || cause_q[HIGH_BIT]))
    else $error("cause register inconsistent");

  a_low_event_held: assert property (@(posedge mclk) disable iff (reset)
    s_low_event ##1 !rd_cause [*2] |=> cause_q[LOW_BIT])
    else $error("low event flag lost");

  a_high_event_flag: assert property (@(posedge mclk) disable iff (reset)
    high_delta_event |=> cause_q[HIGH_BIT] && cause_q[ANY_BIT])
    else $error("high event flag not set");

  a_cause_read_clear: assert property (@(posedge mclk) disable iff (reset)
    rd_cause && !low_delta_event && !high_delta_event |=> !cause_q[ANY_BIT])
    else $error("event flags not cleared by read");

  a_watermark_flag: assert property (@(posedge mclk) disable iff (reset)
    !reset |=> queue_q[WTM_BIT] ==
      ($past(stored_sample_count) >= {1'b0, $past(watermark_level)}))
    else $error("watermark flag wrong");

  a_overwrite_full: assert property (@(posedge mclk) disable iff (reset)
    queue_q[OVW_BIT] |-> queue_q[5:0] == QUEUE_FULL)
    else $error("overwrite flag without full queue");

  a_level_field: assert property (@(posedge mclk) disable iff (reset)
    !reset && stored_sample_count <= QUEUE_FULL |=> queue_q[5:0] == $past(stored_sample_count))
    else $error("stored level field wrong");

  a_level_cap: assert property (@(posedge mclk) disable iff (reset)
    queue_q[5:0] <= QUEUE_FULL)
    else $error("stored level above full");

  a_status_on_tick: assert property (@(posedge mclk) disable iff (reset)
    $rose(status_q[P_DA_BIT]) |-> $past(output_rate_tick))
    else $error("pressure available outside rate tick");

  a_status_hold: assert property (@(posedge mclk) disable iff (reset)
    !reset && !output_rate_tick && !rd_press && !rd_temp |=> status_q == $past(status_q))
    else $error("status changed between rate ticks");

  a_status_unused: assert property (@(posedge mclk) disable iff (reset)
    status_q[7:6] == 2'b00 && status_q[3:2] == 2'b00)
    else $error("unused status bits set");

  a_press_avail: assert property (@(posedge mclk) disable iff (reset)
    s_press_sample ##1 s_rate_wait ##1 s_rate_commit |=> status_q[P_DA_BIT])
    else $error("pressure available not set");

  a_temp_avail: assert property (@(posedge mclk) disable iff (reset)
    s_temp_sample ##1 s_temp_wait ##1 s_temp_commit |=> status_q[T_DA_BIT])
    else $error("temperature available not set");

  a_press_read_clear: assert property (@(posedge mclk) disable iff (reset)
    rd_press && !output_rate_tick |=> !status_q[P_DA_BIT] && !status_q[P_OR_BIT])
    else $error("pressure status not cleared by read");

  a_temp_read_clear: assert property (@(posedge mclk) disable iff (reset)
    rd_temp && !output_rate_tick |=> !status_q[T_DA_BIT] && !status_q[T_OR_BIT])
    else $error("temperature status not cleared by read");

  a_press_offset: assert property (@(posedge mclk) disable iff (reset)
    press_sample_valid && !reg_wr |=> press_q == $past(press_measured) - offs_ext)
    else $error("pressure result not offset corrected");

  a_temp_capture: assert property (@(posedge mclk) disable iff (reset)
    temp_sample_valid |=> temp_q == $past(temp_measured))
    else $error("temperature result not captured");

  a_temp_overrun: assert property (@(posedge mclk) disable iff (reset)
    $rose(status_q[T_OR_BIT]) |->
      $past(output_rate_tick) && $past(status_q[T_DA_BIT] || pend_q[T_DA_BIT]))
    else $error("temperature overrun without prior data");

  a_rdata_status: assert property (@(posedge mclk) disable iff (reset)
    reg_rd && reg_addr == STATUS_ADDR |=> reg_rdata == $past(status_q))
    else $error("status read data wrong");

  a_low_current_out: assert property (@(posedge mclk) disable iff (reset)
    reg_wr && reg_addr == LOW_PWR_ADDR |=> low_current_select == $past(reg_wdata[LC_BIT]))
    else $error("low current select not updated");

endmodule

// ==== tb/host_model.sv ====
/*
 Host controller model: issues byte register reads and writes.
 Assumes the register port timing of the status group: one-cycle strobes,
 read data registered one cycle after the read strobe.
*/
`timescale 1ns/10ps
module host_model (
  input  wire logic       mclk,
  output logic      [7:0] reg_addr,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
  end
  // Released lines show the inverse so stale values never pass for a match
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge mclk);
    d = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule

// ==== tb/testbench.sv ====
/*
 Self-checking bench for the barometer status and result registers.
 Assumes the host model in host_model.sv and the package constants.
*/
`timescale 1ns/10ps
module testbench
  import baro_pkg::*;
;
  logic mclk = 1'b0, reset = 1'b1, tick = 1'b0, pv = 1'b0, tv = 1'b0;
  logic busy = 1'b0, lo = 1'b0, hi = 1'b0, ovw = 1'b0;
  logic [23:0] pm = 24'h0;
  logic [15:0] tm = 16'h0, offs;
  logic [5:0]  cnt = 6'h0;
  logic [4:0]  wm = 5'h0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, a_q;
  logic [23:0] pe;
  logic        reg_rd, reg_wr, lcs, lpr, rd_q = 1'b0;
  logic [7:0]  q[$];
  int          failures = 0, comparisons = 0;
  always #5 mclk = ~mclk;
  host_model i_host_model (.mclk(mclk), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  baro_status_regs i_baro_status_regs (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .output_rate_tick(tick), .press_sample_valid(pv),
    .press_measured(pm), .temp_sample_valid(tv), .temp_measured(tm),
    .trim_reload_busy(busy), .low_delta_event(lo), .high_delta_event(hi),
    .stored_sample_count(cnt), .watermark_level(wm), .queue_overwritten(ovw),
    .low_current_select(lcs), .pressure_lowpass_reset(lpr));
  task automatic stop_test;
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp1(input string n, input logic e, input logic s);
    cmp8(n, {7'h0, e}, {7'h0, s});
  endtask
  task automatic rx(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    i_host_model.rd(a, d);
  endtask
  // Strobes {tick, pressure, temperature, low, high} for one cycle
  task automatic ev(input logic [4:0] m);
    @(posedge mclk);
    {tick, pv, tv, lo, hi} <= m;
    @(posedge mclk);
    {tick, pv, tv, lo, hi} <= 5'h0;
  endtask
  always @(posedge mclk) begin
    if (rd_q)
      cmp8("reg_rdata", q.pop_front(), reg_rdata);
    // Flops are unknown until the first reset edge, so reset cycles are skipped
    if (!reset)
      cmp1("lowpass_reset", rd_q && a_q == FILT_RST_ADDR, lpr);
    rd_q <= reg_rd;
    a_q  <= reg_addr;
  end
  initial begin
    #500000;
    cmp1("run_time", 1'b0, 1'b1);
    stop_test();
  end
  initial begin
    void'($urandom(81));
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    cmp1("low_current_select", 1'b0, lcs);
    i_host_model.wr(LOW_PWR_ADDR, 8'h02);
    rx(LOW_PWR_ADDR, 8'h02);
    i_host_model.wr(LOW_PWR_ADDR, d | 8'h01);
    rx(LOW_PWR_ADDR, 8'h03);
    cmp1("low_current_select", 1'b1, lcs);
    rx(8'h40, 8'h00);
    rx(FILT_RST_ADDR, 8'h00);
    offs = 16'($urandom);
    i_host_model.wr(OFFS_LOW_ADDR, offs[7:0]);
    i_host_model.wr(OFFS_HIGH_ADDR, offs[15:8]);
    pm <= 24'($urandom);
    tm <= 16'($urandom);
    ev(5'h0c);
    rx(STATUS_ADDR, 8'h00);
    ev(5'h10);
    rx(STATUS_ADDR, 8'h03);
    pe = pm - {{8{offs[15]}}, offs};
    rx(PRESS_LOW_ADDR, pe[7:0]);
    rx(PRESS_MID_ADDR, pe[15:8]);
    rx(PRESS_HIGH_ADDR, pe[23:16]);
    rx(TEMP_LOW_ADDR, tm[7:0]);
    rx(TEMP_HIGH_ADDR, tm[15:8]);
    rx(STATUS_ADDR, 8'h00);
    ev(5'h0c);
    ev(5'h10);
    ev(5'h0c);
    ev(5'h10);
    rx(STATUS_ADDR, 8'h33);
    busy <= 1'b1;
    rx(CAUSE_ADDR, 8'h80);
    busy <= 1'b0;
    ev(5'h02);
    rx(CAUSE_ADDR, 8'h06);
    rx(CAUSE_ADDR, 8'h00);
    ev(5'h01);
    rx(CAUSE_ADDR, 8'h05);
    for (int i = 0; i < 12; i++) begin
      cnt <= (i == 0) ? 6'h20 : 6'($urandom_range(32, 0));
      wm  <= (i == 1) ? 5'h00 : 5'($urandom_range(31, 0));
      ovw <= (i == 0) ? 1'b1 : 1'($urandom);
      @(posedge mclk);
      @(posedge mclk);
      rx(QUEUE_ADDR, {cnt >= 6'(wm), ovw && cnt == QUEUE_FULL, cnt});
    end
    @(posedge mclk);
    @(posedge mclk);
    cmp8("queue_size", 8'h00, 8'(q.size()));
    stop_test();
  end
endmodule
